/* File: inc/cpu_regs_pkg.sv */
package cpu_regs_pkg;

	// ----------------------------------------------------------------
	// widths and layout of the status word
	// ----------------------------------------------------------------
	localparam int WORD_W     = 16;
	localparam int BANK_W     = 8;
	localparam int FLAG_W     = 8;
	localparam int IPL_W      = 3;
	localparam int STATUS_W   = 11;
	localparam int DEC_DIGITS = 4;
	localparam int FLAG_C     = 0;
	localparam int FLAG_Z     = 1;
	localparam int FLAG_I     = 2;
	localparam int FLAG_D     = 3;
	localparam int FLAG_X     = 4;
	localparam int FLAG_M     = 5;
	localparam int FLAG_V     = 6;
	localparam int FLAG_N     = 7;
	localparam int SIGN_WIDE  = 15;
	localparam int SIGN_NARROW = 7;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [7:0]  RST_BANK  = 8'h00;
	localparam logic [7:0]  RST_FLAGS = 8'h04;
	localparam logic [2:0]  RST_IPL   = 3'h0;

	// ----------------------------------------------------------------
	// operation codes and selectors
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_IDLE, OP_LOAD, OP_ADD, OP_SUB, OP_SHL, OP_SHR, OP_ROTL,
		OP_ROTR, OP_FLAG_SET, OP_FLAG_CLR, OP_CARRY_SET, OP_CARRY_CLR,
		OP_MASK_SET, OP_MASK_CLR, OP_LEN_SET, OP_LEN_CLR, OP_OVF_CLR
	} op_t;
	typedef enum logic [2:0] {
		SEL_ACC_A, SEL_ACC_B, SEL_IDX_X, SEL_IDX_Y, SEL_STACK,
		SEL_PAGE, SEL_DATA_BANK
	} reg_sel_t;
	typedef enum logic [1:0] {PC_HOLD, PC_INC, PC_BRANCH, PC_JUMP} pc_op_t;
	typedef enum logic [1:0] {SP_HOLD, SP_INC, SP_DEC} sp_op_t;
	typedef enum logic [2:0] {
		CC_CARRY_SET, CC_CARRY_CLR, CC_ZERO_SET, CC_ZERO_CLR,
		CC_OVF_SET, CC_OVF_CLR, CC_NEG_SET, CC_NEG_CLR
	} cond_t;
	typedef enum logic [3:0] {
		AM_ABS, AM_ABS_X, AM_ABS_Y, AM_DIR, AM_DIR_X, AM_DIR_Y,
		AM_STACK_REL, AM_LONG, AM_MOVE_SRC, AM_MOVE_DST
	} addr_mode_t;

endpackage

/* File: core/arith_unit.sv */
`timescale 1ns/10ps
module arith_unit
	import cpu_regs_pkg::*;
(
	// operands
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	input  wire logic        carry_in,
	// mode
	input  wire logic        subtract,
	input  wire logic        decimal,
	input  wire logic        narrow,
	// results
	output logic      [15:0] result,
	output logic             carry_out,
	output logic             overflow
);
	logic [15:0]         b_eff;
	logic [16:0]         bin_sum;
	logic [8:0]          lo_sum;
	logic [15:0]         dec_sum;
	logic [DEC_DIGITS:0] dc;

	// subtract is add of the complement, carry meaning "no borrow"
	assign b_eff   = subtract ? ~b : b;
	assign bin_sum = {1'b0, a} + {1'b0, b_eff} + {16'h0000, carry_in};
	assign lo_sum  = {1'b0, a[7:0]} + {1'b0, b_eff[7:0]}
		+ {8'h00, carry_in};
	assign dc[0]   = carry_in;

	// one decimal digit per slice, carry rippling upward
	for (genvar d = 0; d < DEC_DIGITS; d++) begin : g_digit
		logic [4:0] raw;
		logic       over;
		always_comb begin
			if (subtract) begin
				raw = {1'b0, a[4*d +: 4]} - {1'b0, b[4*d +: 4]}
					- {4'h0, ~dc[d]};
				over = !raw[4];
			end else begin
				raw = {1'b0, a[4*d +: 4]} + {1'b0, b[4*d +: 4]}
					+ {4'h0, dc[d]};
				over = (raw > 5'h09);
			end
		end
		assign dec_sum[4*d +: 4] = subtract
			? (over ? raw[3:0] : raw[3:0] + 4'hA)
			: (over ? raw[3:0] + 4'h6 : raw[3:0]);
		assign dc[d+1] = over;
	end

	// width picks where carry and sign are read
	always_comb begin
		result = decimal ? dec_sum : bin_sum[15:0];
		if (decimal) begin
			carry_out = narrow ? dc[DEC_DIGITS/2] : dc[DEC_DIGITS];
		end else begin
			carry_out = narrow ? lo_sum[8] : bin_sum[16];
		end
		if (narrow) begin
			overflow = (a[SIGN_NARROW] == b_eff[SIGN_NARROW])
				&& (lo_sum[SIGN_NARROW] != a[SIGN_NARROW]);
		end else begin
			overflow = (a[SIGN_WIDE] == b_eff[SIGN_WIDE])
				&& (bin_sum[SIGN_WIDE] != a[SIGN_WIDE]);
		end
	end
endmodule

/* File: core/addr_gen.sv */
`timescale 1ns/10ps
module addr_gen
	import cpu_regs_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// request
	input  wire addr_mode_t  mode,
	input  wire logic [15:0] operand,
	input  wire logic [7:0]  bank_byte,
	// register set
	input  wire logic [15:0] index_x,
	input  wire logic [15:0] index_y,
	input  wire logic        index_narrow,
	input  wire logic [15:0] stack_ptr,
	input  wire logic [7:0]  data_bank,
	input  wire logic [15:0] page_base,
	// result
	output logic      [23:0] eff_addr,
	output logic             extra_cycle
);
	logic [15:0] ix;
	logic [15:0] iy;
	logic [15:0] dir_idx;
	logic [16:0] dir_sum;
	logic [23:0] abs_base;
	logic [23:0] next_eff_addr;
	logic        is_dir;

	// narrow index contributes its low byte only
	assign ix       = index_narrow ? {8'h00, index_x[7:0]} : index_x;
	assign iy       = index_narrow ? {8'h00, index_y[7:0]} : index_y;
	assign abs_base = {data_bank, operand};
	assign is_dir   = (mode == AM_DIR) || (mode == AM_DIR_X)
		|| (mode == AM_DIR_Y);
	assign dir_idx  = (mode == AM_DIR_X) ? ix
		: (mode == AM_DIR_Y) ? iy : 16'h0000;
	// page sum may reach bank 1 when the base is high
	assign dir_sum  = {1'b0, page_base} + {9'h000, operand[7:0]}
		+ {1'b0, dir_idx};

	// address per mode
	always_comb begin
		next_eff_addr = abs_base;
		unique case (mode)
			AM_ABS:       next_eff_addr = abs_base;
			AM_ABS_X:     next_eff_addr = abs_base + {8'h00, ix};
			AM_ABS_Y:     next_eff_addr = abs_base + {8'h00, iy};
			AM_DIR, AM_DIR_X, AM_DIR_Y:
				next_eff_addr = {7'h00, dir_sum};
			AM_STACK_REL: next_eff_addr = {8'h00,
				stack_ptr + {8'h00, operand[7:0]}};
			AM_LONG:      next_eff_addr = {bank_byte, operand};
			AM_MOVE_SRC:  next_eff_addr = {bank_byte, ix};
			AM_MOVE_DST:  next_eff_addr = {bank_byte, iy};
			default:      next_eff_addr = abs_base;
		endcase
	end

	// registered result and the slow-page hint
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			eff_addr    <= 24'h000000;
			extra_cycle <= 1'b0;
		end else begin
			eff_addr    <= next_eff_addr;
			extra_cycle <= is_dir && (page_base[7:0] != 8'h00);
		end
	end
endmodule

/* File: core/cpu_register_set.sv */
// Contract
// - accumulator A is 16 bits, 8 bits wide when data length flag set
// - accumulator B behaves exactly like accumulator A
// - index X and Y are 16 bits, 8 bits when index length flag set
// - indexed modes add the chosen index to the base address
// - block move source is instruction byte three above index X
// - block move destination is instruction byte two above index Y
// - stack pointer is 16 bits, used by calls, interrupts, stack modes
// - counter increment carry bumps the program bank by one
// - branch carry or borrow bumps program bank up or down
// - data bank gives upper address byte in bank-based modes
// - direct page base is 16 bits; direct modes add it, may reach bank 1
// - nonzero low byte of the page base costs extra cycles
// - status word is 11 bits: result flags, control flags, level
// - branches test carry, zero, overflow and negative
// - carry takes arithmetic carry or borrow and shift-out bit
// - zero flag set on zero result, cleared otherwise
// - mask flag blocks maskable interrupts; set on interrupt entry
// - decimal flag makes add and subtract decimal, 4 or 2 digits
// - index length flag 0 gives 16-bit index, 1 gives 8-bit
// - data length flag 0 gives 16-bit data, 1 gives 8-bit
// - overflow flag marks signed result outside the width's range
// - negative flag copies bit 15 or bit 7 of the result
// - every flag set/clearable generically; some have own instructions
`timescale 1ns/10ps
module cpu_register_set
	import cpu_regs_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,

	// operation from the decoder
	input  wire op_t         op,
	input  wire reg_sel_t    reg_sel,
	input  wire logic [15:0] op_data,
	input  wire logic [7:0]  flag_mask,

	// program counter control
	input  wire pc_op_t      pc_op,
	input  wire logic [15:0] branch_offset,
	input  wire logic [23:0] jump_target,

	// stack control
	input  wire sp_op_t      sp_op,

	// interrupt entry
	input  wire logic        irq_entry,
	input  wire logic [2:0]  irq_level,

	// branch test
	input  wire cond_t       branch_cond,
	output logic             branch_taken,
	output logic             irq_enable,

	// address generation
	input  wire addr_mode_t  addr_mode,
	input  wire logic [15:0] addr_operand,
	input  wire logic [7:0]  addr_bank,
	output logic      [23:0] eff_addr,
	output logic             addr_extra_cycle,

	// register contents
	output logic      [15:0] acc_a,
	output logic      [15:0] acc_b,
	output logic      [15:0] index_x,
	output logic      [15:0] index_y,
	output logic      [15:0] stack_ptr,
	output logic      [15:0] prog_counter,
	output logic      [7:0]  program_bank,
	output logic      [7:0]  data_bank,
	output logic      [15:0] direct_page_base,
	output logic      [10:0] processor_status_word,
	output logic      [23:0] fetch_addr
);

	// ----------------------------------------------------------------
	// internal state and helpers
	// ----------------------------------------------------------------
	logic [7:0]  flags;
	logic [7:0]  next_flags;
	logic [2:0]  ipl;
	logic        narrow_data;
	logic        narrow_index;
	logic        use_b;
	logic [15:0] acc_sel;
	logic        is_acc;
	logic        is_index;
	logic        is_arith;
	logic        is_shift;
	logic [15:0] alu_res;
	logic        alu_carry;
	logic        alu_ovf;
	logic [15:0] shift_res;
	logic        shift_carry;
	logic [15:0] acc_res;
	logic [15:0] nz_val;
	logic        nz_narrow;
	logic        nz_update;

	// keep the upper byte when the register runs narrow
	function automatic logic [15:0] merge16(
		input logic [15:0] old_val,
		input logic [15:0] new_val,
		input logic        narrow
	);
		merge16 = narrow ? {old_val[15:8], new_val[7:0]} : new_val;
	endfunction

	function automatic logic is_zero(
		input logic [15:0] v,
		input logic        narrow
	);
		is_zero = narrow ? (v[7:0] == 8'h00) : (v == 16'h0000);
	endfunction

	assign narrow_data  = flags[FLAG_M];
	assign narrow_index = flags[FLAG_X];

	assign use_b    = (reg_sel == SEL_ACC_B);
	assign acc_sel  = use_b ? acc_b : acc_a;
	assign is_acc   = (reg_sel == SEL_ACC_A) || use_b;
	assign is_index = (reg_sel == SEL_IDX_X) || (reg_sel == SEL_IDX_Y);
	assign is_arith = (op == OP_ADD) || (op == OP_SUB);
	assign is_shift = (op == OP_SHL) || (op == OP_SHR)
		|| (op == OP_ROTL) || (op == OP_ROTR);

	// ----------------------------------------------------------------
	// arithmetic and shifts
	// ----------------------------------------------------------------

	// decimal only reaches add and subtract
	arith_unit u_arith (
		.a         (acc_sel),
		.b         (op_data),
		.carry_in  (flags[FLAG_C]),
		.subtract  (op == OP_SUB),
		.decimal   (flags[FLAG_D]),
		.narrow    (narrow_data),
		.result    (alu_res),
		.carry_out (alu_carry),
		.overflow  (alu_ovf)
	);

	// shift-out bit comes from the top of the active width for left shifts, from bit 0 for right
	always_comb begin
		logic cin;
		cin = ((op == OP_ROTL) || (op == OP_ROTR)) ? flags[FLAG_C] : 1'b0;
		if ((op == OP_SHL) || (op == OP_ROTL)) begin
			shift_res   = {acc_sel[14:0], cin};
			shift_carry = narrow_data ? acc_sel[SIGN_NARROW]
				: acc_sel[SIGN_WIDE];
		end else begin
			shift_res   = narrow_data
				? {acc_sel[15:8], cin, acc_sel[7:1]}
				: {cin, acc_sel[15:1]};
			shift_carry = acc_sel[0];
		end
	end

	assign acc_res = is_arith ? alu_res : is_shift ? shift_res : op_data;

	// ----------------------------------------------------------------
	// accumulators
	// ----------------------------------------------------------------

	// accumulator A, narrow writes keep the high byte
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			acc_a <= RST_WORD;
		end else if ((reg_sel == SEL_ACC_A)
				&& ((op == OP_LOAD) || is_arith || is_shift)) begin
			acc_a <= merge16(acc_a, acc_res, narrow_data);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			acc_b <= RST_WORD;
		end else if (use_b && ((op == OP_LOAD) || is_arith || is_shift)) begin
			acc_b <= merge16(acc_b, acc_res, narrow_data);
		end
	end

	// ----------------------------------------------------------------
	// index registers
	// ----------------------------------------------------------------

	// both index registers follow the index length flag
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			index_x <= RST_WORD;
			index_y <= RST_WORD;
		end else if (op == OP_LOAD) begin
			if (reg_sel == SEL_IDX_X) begin
				index_x <= merge16(index_x, op_data, narrow_index);
			end
			if (reg_sel == SEL_IDX_Y) begin
				index_y <= merge16(index_y, op_data, narrow_index);
			end
		end
	end

	// ----------------------------------------------------------------
	// stack, banks and page base
	// ----------------------------------------------------------------

	// a load beats a step in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			stack_ptr <= RST_WORD;
		end else if ((op == OP_LOAD) && (reg_sel == SEL_STACK)) begin
			stack_ptr <= op_data;
		end else begin
			unique case (sp_op)
				SP_INC:  stack_ptr <= stack_ptr + 16'h0001;
				SP_DEC:  stack_ptr <= stack_ptr - 16'h0001;
				default: stack_ptr <= stack_ptr;
			endcase
		end
	end

	// data bank loaded from the low byte
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			data_bank <= RST_BANK;
		end else if ((op == OP_LOAD) && (reg_sel == SEL_DATA_BANK)) begin
			data_bank <= op_data[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			direct_page_base <= RST_WORD;
		end else if ((op == OP_LOAD) && (reg_sel == SEL_PAGE)) begin
			direct_page_base <= op_data;
		end
	end

	// one 24-bit add lets carries fall into the bank byte
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			prog_counter <= RST_WORD;
			program_bank <= RST_BANK;
		end else begin
			unique case (pc_op)
				PC_HOLD: ;
				PC_INC: {program_bank, prog_counter}
					<= {program_bank, prog_counter} + 24'h000001;
				// sign-extended offset gives carry or borrow
				PC_BRANCH: {program_bank, prog_counter}
					<= {program_bank, prog_counter}
					+ {{8{branch_offset[15]}}, branch_offset};
				PC_JUMP: {program_bank, prog_counter} <= jump_target;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------

	// value that the negative and zero flags judge
	always_comb begin
		nz_val    = acc_res;
		nz_narrow = narrow_data;
		nz_update = is_arith || is_shift;
		if (op == OP_LOAD) begin
			nz_val    = op_data;
			nz_narrow = is_index ? narrow_index : narrow_data;
			nz_update = is_acc || is_index;
		end
	end

	always_comb begin
		next_flags = flags;
		if (nz_update) begin
			next_flags[FLAG_Z] = is_zero(nz_val, nz_narrow);
			// sign bit of the active width
			next_flags[FLAG_N] = nz_narrow ? nz_val[SIGN_NARROW]
				: nz_val[SIGN_WIDE];
		end
		unique case (op)
			OP_IDLE, OP_LOAD: ;
			OP_ADD, OP_SUB: begin
				next_flags[FLAG_C] = alu_carry;
				next_flags[FLAG_V] = alu_ovf;
			end
			OP_SHL, OP_SHR, OP_ROTL, OP_ROTR:
				next_flags[FLAG_C] = shift_carry;
			OP_FLAG_SET:  next_flags = flags | flag_mask;
			OP_FLAG_CLR:  next_flags = flags & ~flag_mask;
			OP_CARRY_SET: next_flags[FLAG_C] = 1'b1;
			OP_CARRY_CLR: next_flags[FLAG_C] = 1'b0;
			OP_MASK_SET:  next_flags[FLAG_I] = 1'b1;
			OP_MASK_CLR:  next_flags[FLAG_I] = 1'b0;
			OP_LEN_SET:   next_flags[FLAG_M] = 1'b1;
			OP_LEN_CLR:   next_flags[FLAG_M] = 1'b0;
			OP_OVF_CLR:   next_flags[FLAG_V] = 1'b0;
			default: ;
		endcase
		// interrupt entry sets the mask, winning any clear
		if (irq_entry) begin
			next_flags[FLAG_I] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			flags <= RST_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end

	// level replaced by the requester's on entry
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ipl <= RST_IPL;
		end else if (irq_entry) begin
			ipl <= irq_level;
		end
	end

	// eleven bits, level above the flags
	assign processor_status_word = {ipl, flags};

	// maskable requests pass only with the mask clear
	assign irq_enable = !flags[FLAG_I];

	// ----------------------------------------------------------------
	// branch test and addressing
	// ----------------------------------------------------------------

	always_comb begin
		unique case (branch_cond)
			CC_CARRY_SET: branch_taken = flags[FLAG_C];
			CC_CARRY_CLR: branch_taken = !flags[FLAG_C];
			CC_ZERO_SET:  branch_taken = flags[FLAG_Z];
			CC_ZERO_CLR:  branch_taken = !flags[FLAG_Z];
			CC_OVF_SET:   branch_taken = flags[FLAG_V];
			CC_OVF_CLR:   branch_taken = !flags[FLAG_V];
			CC_NEG_SET:   branch_taken = flags[FLAG_N];
			CC_NEG_CLR:   branch_taken = !flags[FLAG_N];
		endcase
	end

	addr_gen u_addr (
		.ref_clk      (ref_clk),
		.rst_b        (rst_b),
		.mode         (addr_mode),
		.operand      (addr_operand),
		.bank_byte    (addr_bank),
		.index_x      (index_x),
		.index_y      (index_y),
		.index_narrow (narrow_index),
		.stack_ptr    (stack_ptr),
		.data_bank    (data_bank),
		.page_base    (direct_page_base),
		.eff_addr     (eff_addr),
		.extra_cycle  (addr_extra_cycle)
	);

	assign fetch_addr = {program_bank, prog_counter};

endmodule

/* File: sim/cpu_regs_props.sv */
`timescale 1ns/10ps
module cpu_regs_props
	import cpu_regs_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// requests
	input wire op_t         op,
	input wire reg_sel_t    reg_sel,
	input wire logic [15:0] op_data,
	input wire pc_op_t      pc_op,
	input wire logic [15:0] branch_offset,
	input wire logic        irq_entry,
	input wire logic [2:0]  irq_level,
	input wire addr_mode_t  addr_mode,
	input wire logic [7:0]  addr_bank,
	// register contents
	input wire logic        irq_enable,
	input wire logic [23:0] eff_addr,
	input wire logic        addr_extra_cycle,
	input wire logic [15:0] acc_a,
	input wire logic [15:0] index_x,
	input wire logic [15:0] index_y,
	input wire logic [15:0] direct_page_base,
	input wire logic [10:0] processor_status_word,
	input wire logic [23:0] fetch_addr
);
	logic        dir_req;
	logic [23:0] branch_dest;

	// helper terms, so that $past sees plain signals
	assign dir_req = addr_mode inside {AM_DIR, AM_DIR_X, AM_DIR_Y}
		&& direct_page_base[7:0] != 8'h00;
	assign branch_dest = fetch_addr + {{8{branch_offset[15]}}, branch_offset};

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	property p_pc_step;
		pc_op == PC_INC |=> fetch_addr == $past(fetch_addr) + 24'h000001;
	endproperty
	a_pc_step: assert property (p_pc_step)
		else $error("pc step wrong");
	property p_branch;
		pc_op == PC_BRANCH |=> fetch_addr == $past(branch_dest);
	endproperty
	a_branch: assert property (p_branch)
		else $error("branch wrong");
	property p_irq_entry;
		irq_entry |=> processor_status_word[2]
			&& processor_status_word[10:8] == $past(irq_level);
	endproperty
	a_irq_entry: assert property (p_irq_entry)
		else $error("entry wrong");
	property p_mask_set;
		op == OP_MASK_SET |=> !irq_enable;
	endproperty
	a_mask_set: assert property (p_mask_set)
		else $error("mask wrong");
	property p_extra;
		rst_b |=> addr_extra_cycle == $past(dir_req);
	endproperty
	a_extra: assert property (p_extra)
		else $error("extra cycle wrong");
	property p_move_src;
		addr_mode == AM_MOVE_SRC && !processor_status_word[4]
			|=> eff_addr == {$past(addr_bank), $past(index_x)};
	endproperty
	a_move_src: assert property (p_move_src)
		else $error("source wrong");
	property p_move_dst;
		addr_mode == AM_MOVE_DST && !processor_status_word[4]
			|=> eff_addr == {$past(addr_bank), $past(index_y)};
	endproperty
	a_move_dst: assert property (p_move_dst)
		else $error("dest wrong");
	property p_narrow_acc;
		op == OP_LOAD && reg_sel == SEL_ACC_A && processor_status_word[5]
			|=> $stable(acc_a[15:8]) && acc_a[7:0] == $past(op_data[7:0]);
	endproperty
	a_narrow_acc: assert property (p_narrow_acc)
		else $error("narrow wrong");
endmodule

bind cpu_register_set cpu_regs_props u_props (
	.ref_clk, .rst_b, .op, .reg_sel, .op_data, .pc_op, .branch_offset,
	.irq_entry, .irq_level, .addr_mode, .addr_bank, .irq_enable, .eff_addr,
	.addr_extra_cycle, .acc_a, .index_x, .index_y, .direct_page_base,
	.processor_status_word, .fetch_addr
);

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
	import cpu_regs_pkg::*;

	// ---------------------------------------------------------------
	// design connections and model state
	// ---------------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	op_t         op = OP_IDLE;
	reg_sel_t    reg_sel = SEL_ACC_A;
	logic [15:0] op_data = 16'h0000;
	logic [7:0]  flag_mask = 8'h00;
	pc_op_t      pc_op = PC_HOLD;
	logic [15:0] branch_offset = 16'h0000;
	logic [23:0] jump_target = 24'h000000;
	sp_op_t      sp_op = SP_HOLD;
	logic        irq_entry = 1'b0;
	logic [2:0]  irq_level = 3'h0;
	cond_t       branch_cond = CC_CARRY_SET;
	addr_mode_t  addr_mode = AM_ABS;
	logic [15:0] addr_operand = 16'h0000;
	logic [7:0]  addr_bank = 8'h00;
	logic        branch_taken, irq_enable, addr_extra_cycle;
	logic [15:0] acc_a, acc_b, index_x, index_y, stack_ptr, prog_counter;
	logic [15:0] direct_page_base;
	logic [7:0]  program_bank, data_bank;
	logic [10:0] processor_status_word;
	logic [23:0] eff_addr, fetch_addr;
	int          ra[4];
	int          sp, pcf, dt, dp, fl, lvl, ea, ex;
	int          seed = 64;
	int          bad_count = 0;
	int          checks_done = 0;

	always #10 ref_clk = ~ref_clk;

	cpu_register_set DUT (
		.ref_clk, .rst_b, .op, .reg_sel, .op_data, .flag_mask, .pc_op,
		.branch_offset, .jump_target, .sp_op, .irq_entry, .irq_level,
		.branch_cond, .branch_taken, .irq_enable, .addr_mode, .addr_operand,
		.addr_bank, .eff_addr, .addr_extra_cycle, .acc_a, .acc_b, .index_x,
		.index_y, .stack_ptr, .prog_counter, .program_bank, .data_bank,
		.direct_page_base, .processor_status_word, .fetch_addr
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic int rnd(int n);
		return $unsigned($random(seed)) % n;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic model_rst();
		ra = '{default: 0};
		sp = 0;
		pcf = 0;
		dt = 0;
		dp = 0;
		fl = RST_FLAGS;
		lvl = 0;
		ea = 0;
		ex = 0;
	endtask

	// random request; decimal kept off since the model is binary only
	task automatic pick();
		op = op_t'(rnd(18));
		reg_sel = reg_sel_t'(rnd(8));
		if (op inside {[OP_ADD:OP_ROTR]})
			reg_sel = reg_sel_t'(reg_sel[0]);
		op_data = 16'(rnd(65536));
		if (op_data[4])
			op_data[15:8] = 8'hFF;
		flag_mask = 8'(rnd(256)) & 8'hF7;
		pc_op = pc_op_t'(rnd(4));
		branch_offset = 16'(rnd(65536));
		jump_target = 24'(rnd(1 << 24));
		if (jump_target[20])
			jump_target[15:0] = 16'hFFFF;
		sp_op = sp_op_t'(rnd(3));
		irq_entry = rnd(8) == 0;
		irq_level = 3'(rnd(8));
		branch_cond = cond_t'(rnd(8));
		addr_mode = addr_mode_t'(rnd(16));
		addr_operand = 16'(rnd(65536));
		addr_bank = 8'(rnd(256));
		rst_b = rnd(400) != 0;
	endtask

	// one cycle: check branch and enable outputs, model the edge, then compare the registered results
	task automatic step();
		int w, msk, sg, a, b, r, i, k;
		#1;
		k = branch_cond[2:1] < 2 ? branch_cond[2:1] : branch_cond[2:1] + 4;
		chk(branch_taken, fl[k] != branch_cond[0]);
		chk(irq_enable, !fl[2]);
		w = (reg_sel > SEL_ACC_B ? fl[4] : fl[5]) ? 8 : 16;
		msk = (1 << w) - 1;
		sg = 1 << (w - 1);
		i = addr_mode inside {AM_ABS_X, AM_DIR_X, AM_MOVE_SRC} ? ra[2] : ra[3];
		if (fl[4])
			i = i & 255;
		case (addr_mode)
			AM_ABS_X, AM_ABS_Y: ea = (dt << 16) + addr_operand + i;
			AM_DIR: ea = dp + addr_operand[7:0];
			// page sum is 17 bits: a high base wraps within banks 0 and 1
			AM_DIR_X, AM_DIR_Y: ea = (dp + addr_operand[7:0] + i) & 'h1FFFF;
			AM_STACK_REL: ea = (sp + addr_operand[7:0]) & 65535;
			AM_LONG: ea = (addr_bank << 16) + addr_operand;
			AM_MOVE_SRC, AM_MOVE_DST: ea = (addr_bank << 16) + i;
			default: ea = (dt << 16) + addr_operand;
		endcase
		ea = ea & 24'hFFFFFF;
		ex = addr_mode inside {AM_DIR, AM_DIR_X, AM_DIR_Y} && dp[7:0] != 0;
		k = reg_sel;
		a = ra[k[1:0]] & msk;
		b = op_data & msk;
		// carry out is parked at bit w for every kind
		case (op)
			OP_ADD: r = a + b + fl[0];
			OP_SUB: r = a + (~b & msk) + fl[0];
			OP_SHL: r = a << 1;
			OP_ROTL: r = (a << 1) | fl[0];
			OP_SHR: r = (a >> 1) | ((a & 1) << w);
			OP_ROTR: r = (a >> 1) | (fl[0] << (w - 1)) | ((a & 1) << w);
			default: r = b;
		endcase
		// signed overflow at the operating width
		if (op inside {OP_ADD, OP_SUB}) begin
			b = op == OP_SUB ? ~b & msk : b;
			fl[6] = ((a ^ r) & (b ^ r) & sg) != 0;
		end
		if (op inside {[OP_ADD:OP_ROTR]})
			fl[0] = r[w];
		// sign and zero at width, upper byte kept when narrow
		if (op inside {[OP_LOAD:OP_ROTR]} && k < 4) begin
			ra[k] = (ra[k] & ~msk) | (r & msk);
			fl[1] = (r & msk) == 0;
			fl[7] = (r & sg) != 0;
		end
		if (op == OP_LOAD && reg_sel == SEL_PAGE)
			dp = op_data;
		if (op == OP_LOAD && reg_sel == SEL_DATA_BANK)
			dt = op_data[7:0];
		if (op == OP_LOAD && reg_sel == SEL_STACK)
			sp = op_data;
		else
			sp = (sp + (sp_op == SP_INC) - (sp_op == SP_DEC)) & 65535;
		case (op)
			OP_FLAG_SET: fl = fl | flag_mask;
			OP_FLAG_CLR: fl = fl & ~flag_mask;
			OP_CARRY_SET: fl[0] = 1;
			OP_CARRY_CLR: fl[0] = 0;
			OP_MASK_SET: fl[2] = 1;
			OP_MASK_CLR: fl[2] = 0;
			OP_LEN_SET: fl[5] = 1;
			OP_LEN_CLR: fl[5] = 0;
			OP_OVF_CLR: fl[6] = 0;
			default: ;
		endcase
		case (pc_op)
			PC_INC: pcf = pcf + 1;
			PC_BRANCH: pcf = pcf + $signed(branch_offset);
			PC_JUMP: pcf = jump_target;
			default: ;
		endcase
		pcf = pcf & 24'hFFFFFF;
		if (irq_entry) begin
			fl[2] = 1;
			lvl = irq_level;
		end
		if (!rst_b)
			model_rst();
		@(posedge ref_clk);
		#1;
		chk(acc_a, ra[0]);
		chk(acc_b, ra[1]);
		chk(index_x, ra[2]);
		chk(index_y, ra[3]);
		chk(stack_ptr, sp);
		chk(fetch_addr, pcf);
		chk({program_bank, prog_counter}, pcf);
		chk(data_bank, dt);
		chk(direct_page_base, dp);
		chk(processor_status_word, (lvl << 8) | fl);
		chk(eff_addr, ea);
		chk(addr_extra_cycle, ex);
	endtask

	task automatic drv(op_t o, logic [15:0] d, logic [7:0] m);
		op = o;
		reg_sel = SEL_ACC_A;
		op_data = d;
		flag_mask = m;
		irq_entry = 1'b0;
		rst_b = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		model_rst();
		repeat (20) @(posedge ref_clk);
		#1;
		for (int n = 0; n < 3000; n++) begin
			pick();
			step();
		end
		// decimal add: two digits narrow, then four digits wide
		for (int j = 0; j < 2; j++) begin
			drv(OP_FLAG_CLR, 16'h0000, 8'hFF);
			drv(OP_FLAG_SET, 16'h0000, j ? 8'h08 : 8'h28);
			drv(OP_LOAD, j ? 16'h1999 : 16'h0045, 8'h00);
			drv(OP_ADD, j ? 16'h0001 : 16'h0055, 8'h00);
			chk(acc_a & (j ? 16'hFFFF : 16'h00FF), j ? 16'h2000 : 16'h0000);
			chk(processor_status_word[0], !j);
		end
		// decimal subtract, wide: borrow ripples through three digits
		drv(OP_FLAG_CLR, 16'h0000, 8'hFF);
		drv(OP_FLAG_SET, 16'h0000, 8'h09);
		drv(OP_LOAD, 16'h2000, 8'h00);
		drv(OP_SUB, 16'h0001, 8'h00);
		chk(acc_a, 16'h1999);
		chk(processor_status_word[0], 1'b1);
		give_verdict();
	end

	// hang guard
	initial begin
		#400000;
		bad_count++;
		give_verdict();
	end
endmodule
